// file: design/exc_params.svh
// constants for the exception-taking unit: offsets, vectors, field positions, reset values
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH
`define OFF_BP_ADDR      12'h000
`define OFF_THERM_A      12'h004
`define OFF_THERM_B      12'h008
`define OFF_MSR          12'h00c
`define OFF_SR_PC        12'h010
`define OFF_SR_STATE     12'h014
`define OFF_IRQ_STATUS   12'h018
`define OFF_IRQ_MASK     12'h01c
`define OFF_FETCH_PC     12'h020
`define OFF_DEBUG_CTRL   12'h024
`define VEC_SYS_MGMT     32'h0000_1400
`define VEC_THERMAL      32'h0000_1700
`define VEC_DSI          32'h0000_0300
`define VEC_TRACE        32'h0000_0d00
`define VEC_IBP          32'h0000_1300
`define VEC_EXT          32'h0000_0500
`define BASE_HIGH        32'hfff0_0000
`define MSR_POW          18
`define MSR_ILE          16
`define MSR_EE           15
`define MSR_PR           14
`define MSR_FP           13
`define MSR_ME           12
`define MSR_FE0          11
`define MSR_SE           10
`define MSR_BE           9
`define MSR_FE1          8
`define MSR_IP           6
`define MSR_IR           5
`define MSR_DR           4
`define MSR_PM           2
`define MSR_RI           1
`define MSR_LE           0
`define SAVE_RESTORE_STATE_KEEP_MASK   32'h87c0_ffff
`define MSR_RESET        32'h0000_0040
`define THERM_TIE_BIT    1
`define THERM_TRIP_BIT   0
`define IRQ_SMI_BIT      0
`define IRQ_THERM_BIT    1
`define IRQ_DSI_BIT      2
`define IRQ_SOFTSTOP_BIT 3
`endif

// file: design/exc_pkg.sv
// types shared by the exception-taking unit
package exc_pkg;
	// kind of exception being taken
	typedef enum logic [2:0] {
		cause_none = 3'h0,
		cause_smi  = 3'h1,
		cause_ext  = 3'h2,
		cause_therm = 3'h3,
		cause_dsi  = 3'h4,
		cause_ibp  = 3'h5,
		cause_trace = 3'h6
	} cause_t;
	// one data access from the load/store side
	typedef struct packed {
		logic        valid;
		logic        is_store;
		logic [31:0] ea;
	} data_access_t;
	// one exception redirect towards fetch
	typedef struct packed {
		logic        valid;
		logic [31:0] target;
		cause_t      cause;
	} redirect_t;
endpackage

// file: design/exc_unit.sv
// exception-taking unit: system management, thermal, data breakpoint and soft stop
`timescale 1ns/1ns
`include "exc_params.svh"
module exc_unit #(
	parameter int ADDR_W = 12
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  sys_mgmt_irq_in,
	input  wire logic                  ext_irq_in,
	input  wire logic                  thermal_trip_a,
	input  wire logic                  thermal_trip_b,
	input  wire exc_pkg::data_access_t data_access,
	input  wire logic [31:0]           next_instr_ea,
	input  wire logic                  instr_complete,
	input  wire logic                  instr_fault,
	input  wire logic                  pipe_empty,
	input  wire logic                  store_queue_empty,
	input  wire logic                  trace_cond,
	input  wire logic                  ibp_cond,
	input  wire logic                  soft_stop_req,
	output exc_pkg::redirect_t         redirect,
	output logic                       dispatch_stop,
	output logic                       soft_stop,
	output logic                       irq
);
	// elaboration refuses a map that cannot hold every offset
	if (ADDR_W < 6) begin
		$error("ADDR_W too small for the register map");
	end

	// state machine of exception entry
	// one-hot, all codes reachable
	typedef enum logic [3:0] {
		st_run   = 4'b0001,
		st_drain = 4'b0010,
		st_wait  = 4'b0100,
		st_take  = 4'b1000
	} entry_state_t;

	// software visible registers
	logic [31:0]     data_breakpoint_address;    // breakpoint address and enables
	logic [31:0]     thermal_threshold_a;        // control of comparator a
	logic [31:0]     thermal_threshold_b;        // control of comparator b
	logic [31:0]     machine_state_reg;          // machine state
	logic [31:0]     save_restore_pc;            // saved resume address
	logic [31:0]     save_restore_state;         // saved machine state
	logic [3:0]      irq_status;                 // sticky event bits
	logic [3:0]      irq_mask;                   // enables onto irq
	logic [31:0]     fetch_pc;                   // last redirect target
	logic            onchip_debug_ctrl;          // soft stop enable from debug side
	entry_state_t    state;                      // entry sequencer
	exc_pkg::cause_t pend_cause;                 // cause being serviced
	// pin synchronisers
	logic [2:0]      smi_sync;                   // pin synchroniser for smi
	logic [2:0]      ext_sync;                   // pin synchroniser for external irq
	logic            smi_lvl;                    // filtered smi level
	logic            ext_lvl;                    // filtered external level
	logic            ss_used;                    // soft stop already given before ibp
	// decoded bus strobes
	logic            wr_en;                      // apb write this cycle
	logic            rd_en;                      // apb read this cycle
	logic            addr_ok;                    // address is mapped
	logic            therm_req;                  // thermal request level
	logic            dsi_hit;                    // data breakpoint match
	logic            ibp_ss;                     // breakpoint soft stop allowed
	logic            ev_soft;                    // soft stop event this cycle
	logic [3:0]      events;                     // event pulses into status
	// entry values
	logic [31:0]     next_msr;                   // machine state after entry
	logic [31:0]     vec_base;                   // base selected by prefix
	logic [31:0]     next_target;                // vector target of the entry

	// decode one register offset
	// upper bits must be zero
	function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		return a[5:0] == off[5:0] && a[ADDR_W-1:6] == '0;
	endfunction

	// apb strobes, access phase
	// unmapped: pslverr only
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign addr_ok = is_reg(paddr, `OFF_BP_ADDR) || is_reg(paddr, `OFF_THERM_A) ||
		is_reg(paddr, `OFF_THERM_B) || is_reg(paddr, `OFF_MSR) || is_reg(paddr, `OFF_SR_PC) ||
		is_reg(paddr, `OFF_SR_STATE) || is_reg(paddr, `OFF_IRQ_STATUS) ||
		is_reg(paddr, `OFF_IRQ_MASK) || is_reg(paddr, `OFF_FETCH_PC) || is_reg(paddr, `OFF_DEBUG_CTRL);

	// synchronise pins; a change counts once stages two and three agree
	// stage one never decides
	// a one-cycle glitch is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smi_sync <= 3'h0;
			ext_sync <= 3'h0;
			smi_lvl  <= 1'b0;
			ext_lvl  <= 1'b0;
		end else begin
			smi_sync <= {smi_sync[1:0], sys_mgmt_irq_in};
			ext_sync <= {ext_sync[1:0], ext_irq_in};
			if (smi_sync[1] == smi_sync[2]) begin
				smi_lvl <= smi_sync[2];
			end
			if (ext_sync[1] == ext_sync[2]) begin
				ext_lvl <= ext_sync[2];
			end
		end
	end

	// thermal request: enabled trip of either comparator, masked by ee
	// comparators share pclk
	// masked: no status set
	assign therm_req = ((thermal_trip_a && thermal_threshold_a[`THERM_TIE_BIT]) ||
		(thermal_trip_b && thermal_threshold_b[`THERM_TIE_BIT])) &&
		machine_state_reg[`MSR_EE];

	// data breakpoint compare at doubleword granularity
	// low three bits ignored
	// both enables clear: off
	assign dsi_hit = data_access.valid &&
		data_access.ea[31:3] == data_breakpoint_address[31:3] &&
		data_breakpoint_address[2] == machine_state_reg[`MSR_DR] &&
		((data_access.is_store && data_breakpoint_address[1]) ||
		 (!data_access.is_store && data_breakpoint_address[0]));

	// breakpoint soft stop only if none was given before this breakpoint
	assign ibp_ss = ibp_cond && !ss_used;
	// soft stop sources when enabled; debug request always
	// data hit also soft-stops
	// debug request: no mask
	assign ev_soft = soft_stop_req ||
		(onchip_debug_ctrl && (dsi_hit || ibp_ss || (trace_cond && !ibp_cond && !ss_used)));
	assign events = {ev_soft, dsi_hit, therm_req, smi_lvl};

	// machine state on entry and saved copy
	// endian, check, prefix pass
	// unlisted bits are kept
	always_comb begin
		next_msr = machine_state_reg;
		next_msr[`MSR_POW] = 1'b0;
		next_msr[`MSR_EE]  = 1'b0;
		next_msr[`MSR_PR]  = 1'b0;
		next_msr[`MSR_FP]  = 1'b0;
		next_msr[`MSR_FE0] = 1'b0;
		next_msr[`MSR_SE]  = 1'b0;
		next_msr[`MSR_BE]  = 1'b0;
		next_msr[`MSR_FE1] = 1'b0;
		next_msr[`MSR_IR]  = 1'b0;
		next_msr[`MSR_DR]  = 1'b0;
		next_msr[`MSR_PM]  = 1'b0;
		next_msr[`MSR_RI]  = 1'b0;
		next_msr[`MSR_LE]  = machine_state_reg[`MSR_ILE];
	end

	// vector base and offset per cause
	// prefix set: high base
	// offsets clear of base bits
	always_comb begin
		vec_base = machine_state_reg[`MSR_IP] ? `BASE_HIGH : 32'h0000_0000;
		unique case (pend_cause)
			exc_pkg::cause_smi:   next_target = vec_base | `VEC_SYS_MGMT;
			exc_pkg::cause_therm: next_target = vec_base | `VEC_THERMAL;
			exc_pkg::cause_dsi:   next_target = vec_base | `VEC_DSI;
			exc_pkg::cause_ibp:   next_target = vec_base | `VEC_IBP;
			exc_pkg::cause_trace: next_target = vec_base | `VEC_TRACE;
			exc_pkg::cause_ext:   next_target = vec_base | `VEC_EXT;
			default:              next_target = vec_base;
		endcase
	end

	// one exception in flight
	// late requests wait for run
	// stop stands until redirect
	// entry sequencer: stop, drain, reach recoverable point, take
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= st_run;
			pend_cause    <= exc_pkg::cause_none;
			dispatch_stop <= 1'b0;
			redirect      <= '0;
		end else begin
			redirect.valid <= 1'b0;
			unique case (state)
				st_run: begin
					// immediate synchronous faults first
					if (dsi_hit && !onchip_debug_ctrl) begin
						pend_cause <= exc_pkg::cause_dsi;
						state <= st_take;
					end else if (ibp_cond && !onchip_debug_ctrl) begin
						pend_cause <= exc_pkg::cause_ibp;
						state <= st_take;
					end else if (trace_cond && !onchip_debug_ctrl) begin
						pend_cause <= exc_pkg::cause_trace;
						state <= st_take;
					end else if (smi_lvl && machine_state_reg[`MSR_EE]) begin
						// management, gated like ext
						pend_cause <= exc_pkg::cause_smi;
						dispatch_stop <= 1'b1;
						state <= st_drain;
					end else if (ext_lvl && machine_state_reg[`MSR_EE]) begin
						// external after management
						pend_cause <= exc_pkg::cause_ext;
						dispatch_stop <= 1'b1;
						state <= st_drain;
					end else if (therm_req) begin
						// thermal last, gated
						pend_cause <= exc_pkg::cause_therm;
						dispatch_stop <= 1'b1;
						state <= st_drain;
					end
				end
				st_drain: begin
					// a fault raised while draining is taken first, request stays pending
					if (instr_fault) begin
						pend_cause <= exc_pkg::cause_dsi;
						state <= st_take;
					end else if (instr_complete || pipe_empty) begin
						state <= st_wait;
					end
				end
				st_wait: begin
					// recoverable: completion halted, store queue drained
					if (pipe_empty && store_queue_empty) begin
						state <= st_take;
					end
				end
				st_take: begin
					// save, vector, resume
					redirect.valid  <= 1'b1;
					redirect.target <= next_target;
					redirect.cause  <= pend_cause;
					dispatch_stop   <= 1'b0;
					state           <= st_run;
				end
				default: state <= st_run;
			endcase
		end
	end

	// entry beats a sw write
	// in the same cycle
	// machine state and save/restore registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			machine_state_reg  <= `MSR_RESET;
			save_restore_pc    <= 32'h0000_0000;
			save_restore_state <= 32'h0000_0000;
			fetch_pc           <= 32'h0000_0000;
		end else if (state == st_take) begin
			save_restore_pc    <= next_instr_ea;
			save_restore_state <= machine_state_reg & `SAVE_RESTORE_STATE_KEEP_MASK;
			machine_state_reg  <= next_msr;
			fetch_pc           <= next_target;
		end else if (wr_en && is_reg(paddr, `OFF_MSR)) begin
			machine_state_reg <= pwdata;
		end else if (wr_en && is_reg(paddr, `OFF_SR_PC)) begin
			save_restore_pc <= pwdata;
		end else if (wr_en && is_reg(paddr, `OFF_SR_STATE)) begin
			save_restore_state <= pwdata;
		end
	end

	// software configuration registers
	// writes land in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_breakpoint_address <= 32'h0000_0000;
			thermal_threshold_a     <= 32'h0000_0000;
			thermal_threshold_b     <= 32'h0000_0000;
			irq_mask                <= 4'h0;
			onchip_debug_ctrl       <= 1'b0;
		end else if (wr_en) begin
			if (is_reg(paddr, `OFF_BP_ADDR)) begin
				data_breakpoint_address <= pwdata;
			end
			if (is_reg(paddr, `OFF_THERM_A)) begin
				thermal_threshold_a <= pwdata;
			end
			if (is_reg(paddr, `OFF_THERM_B)) begin
				thermal_threshold_b <= pwdata;
			end
			if (is_reg(paddr, `OFF_IRQ_MASK)) begin
				irq_mask <= pwdata[3:0];
			end
			if (is_reg(paddr, `OFF_DEBUG_CTRL)) begin
				onchip_debug_ctrl <= pwdata[0];
			end
		end
	end

	// soft stop pulse and one-per-breakpoint guard
	// guard clears on complete
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_stop <= 1'b0;
			ss_used   <= 1'b0;
		end else begin
			soft_stop <= ev_soft;
			if (instr_complete) begin
				ss_used <= 1'b0;
			end else if (ev_soft) begin
				ss_used <= 1'b1;
			end
		end
	end

	// sticky status, write one to clear, set wins
	// set wins over clear
	// irq one cycle behind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 4'h0;
			irq        <= 1'b0;
		end else begin
			if (wr_en && is_reg(paddr, `OFF_IRQ_STATUS)) begin
				irq_status <= (irq_status & ~pwdata[3:0]) | events;
			end else begin
				irq_status <= irq_status | events;
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// apb read data and response
	// zero wait states
	// data stands in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (is_reg(paddr, `OFF_BP_ADDR)) prdata <= data_breakpoint_address;
				else if (is_reg(paddr, `OFF_THERM_A)) prdata <= thermal_threshold_a;
				else if (is_reg(paddr, `OFF_THERM_B)) prdata <= thermal_threshold_b;
				else if (is_reg(paddr, `OFF_MSR)) prdata <= machine_state_reg;
				else if (is_reg(paddr, `OFF_SR_PC)) prdata <= save_restore_pc;
				else if (is_reg(paddr, `OFF_SR_STATE)) prdata <= save_restore_state;
				else if (is_reg(paddr, `OFF_IRQ_STATUS)) prdata <= {28'h0, irq_status};
				else if (is_reg(paddr, `OFF_IRQ_MASK)) prdata <= {28'h0, irq_mask};
				else if (is_reg(paddr, `OFF_FETCH_PC)) prdata <= fetch_pc;
				else if (is_reg(paddr, `OFF_DEBUG_CTRL)) prdata <= {31'h0, onchip_debug_ctrl};
			end
		end
	end
endmodule

// file: testbench/exc_sys_model.sv
// system logic and pipeline model facing the exception-taking unit
`timescale 1ns/1ns
module exc_sys_model (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               smi_go,
	input  wire logic               retire,
	input  wire logic [3:0]         drain_cycles,
	input  wire logic               dispatch_stop,
	input  wire exc_pkg::redirect_t redirect,
	output logic                    sys_mgmt_irq_in,
	output logic                    instr_complete,
	output logic                    pipe_empty,
	output logic                    store_queue_empty
);
	logic [3:0] drain_cnt; // cycles spent draining so far
	// request pin: raised on command, held until the handler has started
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_mgmt_irq_in <= 1'b0;
		end else if (smi_go) begin
			sys_mgmt_irq_in <= 1'b1;
		end else if (redirect.valid && redirect.cause == exc_pkg::cause_smi) begin
			sys_mgmt_irq_in <= 1'b0;
		end
	end
	// drain timer: slow or prompt pipeline once dispatch stops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drain_cnt <= 4'h0;
		end else if (!dispatch_stop) begin
			drain_cnt <= 4'h0;
		end else if (drain_cnt != drain_cycles) begin
			drain_cnt <= drain_cnt + 4'h1;
		end
	end
	// the pipe empties and stores drain together at the end of the timer
	assign pipe_empty = dispatch_stop && drain_cnt == drain_cycles;
	assign store_queue_empty = pipe_empty;
	assign instr_complete = pipe_empty || retire;
endmodule

// file: testbench/exc_unit_assertions.sv
// concurrent checks on the exception-taking unit's ports
`timescale 1ns/1ns
module exc_unit_assertions #(
	parameter int ADDR_W = 12
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               pipe_empty,
	input wire logic               store_queue_empty,
	input wire logic               ibp_cond,
	input wire logic               soft_stop_req,
	input wire exc_pkg::redirect_t redirect,
	input wire logic               dispatch_stop,
	input wire logic               soft_stop
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// management entry lands on its own vector above a legal base
	property p_smi_vector;
		redirect.valid && redirect.cause == exc_pkg::cause_smi
			|-> redirect.target[19:0] == 20'h01400 && redirect.target[31:20] inside {12'h000, 12'hfff};
	endproperty
	a_smi_vector: assert property (p_smi_vector) else $error("smi redirect target wrong");
	// thermal entry vector
	property p_therm_vector;
		redirect.valid && redirect.cause == exc_pkg::cause_therm |-> redirect.target[19:0] == 20'h01700;
	endproperty
	a_therm_vector: assert property (p_therm_vector) else $error("thermal redirect target wrong");
	// management entry only after dispatch stopped and pipe drained
	property p_smi_drained;
		redirect.valid && redirect.cause == exc_pkg::cause_smi |-> $past(dispatch_stop) && $past(pipe_empty);
	endproperty
	a_smi_drained: assert property (p_smi_drained) else $error("smi taken before drain");
	// thermal entry only at a recoverable halt with stores drained
	property p_therm_recoverable;
		redirect.valid && redirect.cause == exc_pkg::cause_therm |-> $past(store_queue_empty) && $past(dispatch_stop);
	endproperty
	a_therm_recoverable: assert property (p_therm_recoverable) else $error("thermal taken early");
	// data breakpoint raises data storage vector
	property p_dsi_vector;
		redirect.valid && redirect.cause == exc_pkg::cause_dsi |-> redirect.target[19:0] == 20'h00300;
	endproperty
	a_dsi_vector: assert property (p_dsi_vector) else $error("data storage target wrong");
	// trace never wins over a simultaneous instruction breakpoint
	property p_ibp_over_trace;
		redirect.valid && redirect.cause == exc_pkg::cause_trace |-> !$past(ibp_cond, 2);
	endproperty
	a_ibp_over_trace: assert property (p_ibp_over_trace) else $error("trace beat breakpoint");
	// a soft stop is not followed by the exception it replaces
	property p_softstop_replaces;
		soft_stop |=> (!(redirect.valid && redirect.cause inside {exc_pkg::cause_dsi, exc_pkg::cause_ibp,
			exc_pkg::cause_trace}))[*3];
	endproperty
	a_softstop_replaces: assert property (p_softstop_replaces) else $error("exception after soft stop");
	// debug request yields a soft stop shortly
	property p_softstop_req;
		$rose(soft_stop_req) && !dispatch_stop |-> ##[1:4] soft_stop;
	endproperty
	a_softstop_req: assert property (p_softstop_req) else $error("debug request gave no soft stop");
	// dispatch stays stopped until the redirect leaves
	property p_stop_until_redirect;
		$fell(dispatch_stop) |-> redirect.valid;
	endproperty
	a_stop_until_redirect: assert property (p_stop_until_redirect) else $error("dispatch resumed early");
endmodule
bind exc_unit exc_unit_assertions #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
	.pipe_empty(pipe_empty), .store_queue_empty(store_queue_empty), .ibp_cond(ibp_cond),
	.soft_stop_req(soft_stop_req), .redirect(redirect), .dispatch_stop(dispatch_stop), .soft_stop(soft_stop));

// file: testbench/tb_sysmgmt_thermal_breakpoint_exceptions.sv
// self-checking bench for the exception-taking unit
`timescale 1ns/1ns
`include "exc_params.svh"
module tb_sysmgmt_thermal_breakpoint_exceptions;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err; // bus, status
	logic                  dispatch_stop, soft_stop, ext_irq_in, thermal_trip_a, thermal_trip_b; // events
	logic                  sys_mgmt_irq_in, instr_complete, instr_fault, pipe_empty, store_queue_empty;
	logic                  trace_cond, ibp_cond, soft_stop_req, smi_go, retire; // debug and model controls
	logic [11:0]           paddr;                                  // register byte address
	logic [31:0]           pwdata, prdata, next_instr_ea, rd, msr_v, bp, ea, drv; // data and scratch
	logic [3:0]            drain_cycles;                           // model drain time
	exc_pkg::data_access_t data_access;                            // load/store access
	exc_pkg::redirect_t    redirect, last_r;                       // redirect and last one seen
	int                    n_mismatch, checks_done, n_redir, n_ss, seed, i, base_r, base_s, hit;
	exc_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sys_mgmt_irq_in, .ext_irq_in, .thermal_trip_a, .thermal_trip_b, .data_access, .next_instr_ea,
		.instr_complete, .instr_fault, .pipe_empty, .store_queue_empty, .trace_cond, .ibp_cond,
		.soft_stop_req, .redirect, .dispatch_stop, .soft_stop, .irq);
	exc_sys_model far_end (.pclk, .presetn, .smi_go, .retire, .drain_cycles, .dispatch_stop, .redirect,
		.sys_mgmt_irq_in, .instr_complete, .pipe_empty, .store_queue_empty);
	// clock: 40 ns period
	always #20 pclk = ~pclk;
	// count redirects and soft stops as they leave the unit
	always @(posedge pclk) begin
		if (redirect.valid === 1'b1) begin
			n_redir++;
			last_r = redirect;
		end
		if (soft_stop === 1'b1) n_ss++;
	end
	// verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one compare of a 32-bit result
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one bus transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_mismatch++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read a register and compare
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	// bounded wait for a redirect count
	task automatic wait_redir(input int target);
		int n;
		for (n = 0; n < 80 && n_redir < target; n++) @(posedge pclk);
		if (n_redir < target) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// state after entry: keep ile, me, prefix; le follows ile
	function automatic logic [31:0] entry_msr(input logic [31:0] m);
		return (m & 32'h0001_1040) | {31'h0, m[16]};
	endfunction
	// breakpoint match on doubleword, translate flag and direction enable
	function automatic int bp_hit(input logic [31:0] b, input logic [31:0] e, input logic st, input logic dr);
		return int'(e[31:3] == b[31:3] && b[2] == dr && (st ? b[1] : b[0]));
	endfunction
	// main sequence
	initial begin
		seed = 32'h82f0409b;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, ext_irq_in, thermal_trip_a, thermal_trip_b, instr_fault} = '0;
		{trace_cond, ibp_cond, soft_stop_req, smi_go, retire, paddr, pwdata, drain_cycles} = '0;
		data_access = '0;
		next_instr_ea = 32'h0000_2000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk("msr reset", `OFF_MSR, `MSR_RESET);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		// management request with external pending, slow drain
		msr_v = 32'hffff_d053;
		apb(1'b1, `OFF_MSR, msr_v);
		apb(1'b1, `OFF_IRQ_MASK, 32'hf);
		next_instr_ea <= $random(seed) & 32'hffff_fffc;
		drain_cycles <= 4'h6;
		smi_go <= 1'b1;
		@(posedge pclk);
		smi_go <= 1'b0;
		ext_irq_in <= 1'b1;
		wait_redir(1);
		chk("smi cause", exc_pkg::cause_smi, last_r.cause);
		chk("smi target", `BASE_HIGH | `VEC_SYS_MGMT, last_r.target);
		rchk("save pc", `OFF_SR_PC, next_instr_ea);
		rchk("save state", `OFF_SR_STATE, msr_v & 32'h87c0_ffff);
		apb(1'b0, `OFF_MSR, 32'h0);
		chk("entry msr", entry_msr(msr_v), rd & 32'h0005_ff77);
		repeat (12) @(posedge pclk);
		chk("ext held off", 32'h1, n_redir);
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'b1, `OFF_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `OFF_IRQ_STATUS, 32'hf);
		apb(1'b1, `OFF_IRQ_MASK, 32'hf);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apb(1'b1, `OFF_MSR, msr_v);
		wait_redir(2);
		ext_irq_in <= 1'b0;
		chk("ext cause", exc_pkg::cause_ext, last_r.cause);
		chk("ext target", `BASE_HIGH | `VEC_EXT, last_r.target);
		// thermal trip with low prefix, prompt drain, then masked by ee
		apb(1'b1, `OFF_THERM_A, 32'h2);
		apb(1'b1, `OFF_MSR, msr_v & ~32'h40);
		drain_cycles <= 4'h0;
		thermal_trip_a <= 1'b1;
		wait_redir(3);
		thermal_trip_a <= 1'b0;
		chk("therm cause", exc_pkg::cause_therm, last_r.cause);
		chk("therm target", `VEC_THERMAL, last_r.target);
		apb(1'b1, `OFF_THERM_B, 32'h2);
		apb(1'b1, `OFF_MSR, msr_v & ~32'h8000);
		thermal_trip_b <= 1'b1;
		repeat (16) @(posedge pclk);
		chk("therm masked", 32'h3, n_redir);
		thermal_trip_b <= 1'b0;
		apb(1'b1, `OFF_IRQ_STATUS, 32'hf);
		// data breakpoint: random addresses, first one a forced store hit
		for (i = 0; i < 12; i++) begin
			bp = $random(seed);
			drv = $random(seed);
			if (i == 0) begin
				bp = bp | 32'h6;
				drv = 32'h3f;
			end
			ea = drv[1] ? {bp[31:3], drv[4:2]} : $random(seed);
			hit = bp_hit(bp, ea, drv[5], drv[0]);
			base_r = n_redir;
			apb(1'b1, `OFF_BP_ADDR, bp);
			apb(1'b1, `OFF_MSR, {27'h0, drv[0], 4'h0} | 32'h40);
			data_access <= '{1'b1, drv[5], ea};
			@(posedge pclk);
			data_access.valid <= 1'b0;
			repeat (5) @(posedge pclk);
			chk("dsi count", base_r + hit, n_redir);
			if (hit != 0) chk("dsi target", `BASE_HIGH | `VEC_DSI, last_r.target);
		end
		// soft stop enabled: breakpoint becomes a soft stop
		apb(1'b1, `OFF_DEBUG_CTRL, 32'h1);
		apb(1'b1, `OFF_BP_ADDR, 32'h0000_1006);
		apb(1'b1, `OFF_MSR, 32'h50);
		base_r = n_redir;
		base_s = n_ss;
		data_access <= '{1'b1, 1'b1, 32'h0000_1004};
		@(posedge pclk);
		data_access.valid <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("no dsi", base_r, n_redir);
		chk("bp soft stop", base_s + 1, n_ss);
		retire <= 1'b1;
		@(posedge pclk);
		retire <= 1'b0;
		// trace then breakpoint before completion: one soft stop only
		base_s = n_ss;
		trace_cond <= 1'b1;
		@(posedge pclk);
		trace_cond <= 1'b0;
		ibp_cond <= 1'b1;
		@(posedge pclk);
		ibp_cond <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("one soft stop", base_s + 1, n_ss);
		retire <= 1'b1;
		@(posedge pclk);
		retire <= 1'b0;
		// debug request with ee clear still stops
		apb(1'b1, `OFF_MSR, 32'h40);
		base_s = n_ss;
		soft_stop_req <= 1'b1;
		@(posedge pclk);
		soft_stop_req <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("request stop", base_s + 1, n_ss);
		// soft stop off: breakpoint beats trace, trace alone vectors
		apb(1'b1, `OFF_DEBUG_CTRL, 32'h0);
		for (i = 0; i < 2; i++) begin
			base_r = n_redir;
			ibp_cond <= (i == 0);
			trace_cond <= 1'b1;
			@(posedge pclk);
			ibp_cond <= 1'b0;
			trace_cond <= 1'b0;
			wait_redir(base_r + 1);
			chk("bp or trace", (i != 0) ? `VEC_TRACE : `VEC_IBP, last_r.target & 32'h000f_ffff);
		end
		close_out();
	end
endmodule
